// >>> rtl/cprc_pkg.sv
/*
 Package for the codec PLL and record configuration register bank: register
 offsets, field positions, reset values, timing constants and carrier structs.
 Assumes a single 125 MHz clock domain and an AXI4-Lite register bus.
*/
package cprc_pkg;

	localparam int unsigned CLK_HZ = 125000000;

	// Printed offsets are not all word multiples; they are register indices
	localparam logic [15:0] IDX_PLL_BASE = 16'h4002;
	localparam logic [15:0] IDX_JACK     = 16'h4008;
	localparam logic [15:0] IDX_LMIX_A   = 16'h400A;
	localparam logic [15:0] IDX_LMIX_B   = 16'h400B;
	localparam logic [15:0] IDX_RMIX_A   = 16'h400C;
	localparam logic [15:0] IDX_RMIX_B   = 16'h400D;
	localparam logic [15:0] IDX_LVOL     = 16'h400E;
	localparam logic [15:0] IDX_RVOL     = 16'h400F;
	localparam logic [15:0] IDX_BIAS     = 16'h4010;
	localparam logic [15:0] IDX_LVL0     = 16'h4011;
	localparam int unsigned PLL_BYTES    = 6;

	// PLL byte reset values, byte 0 first
	localparam logic [7:0] RST_PLL0 = 8'h00;
	localparam logic [7:0] RST_PLL1 = 8'hFD;
	localparam logic [7:0] RST_PLL2 = 8'h00;
	localparam logic [7:0] RST_PLL3 = 8'h0C;
	localparam logic [7:0] RST_PLL4 = 8'h10;
	localparam logic [7:0] RST_PLL5 = 8'h00;
	localparam logic [7:0] RST_BYTE = 8'h00;

	// Writable bits per register; reserved bits read zero
	localparam logic [7:0] MASK_PLL4 = 8'h7F;
	localparam logic [7:0] MASK_PLL5 = 8'h01;
	localparam logic [7:0] MASK_JACK = 8'hF1;
	localparam logic [7:0] MASK_MIXA = 8'h7F;
	localparam logic [7:0] MASK_MIXB = 8'h1F;
	localparam logic [7:0] MASK_VOL  = 8'hFF;
	localparam logic [7:0] MASK_BIAS = 8'h0D;
	localparam logic [7:0] MASK_LVL0 = 8'hFF;

	localparam int unsigned POS_LOCK = 1;

	// Lock wait after enable and debounce/ramp time units
	localparam int unsigned LOCK_US        = 100;
	localparam int unsigned LOCK_CYC       = (LOCK_US * (CLK_HZ / 1000000));
	localparam int unsigned MS_CYC         = CLK_HZ / 1000;
	localparam int unsigned DEB_BASE_MS    = 5;
	localparam int unsigned RAMP_BASE_MS   = 24;
	localparam int unsigned VOL_STEPS      = 64;

	localparam logic [1:0] AXI_OKAY   = 2'b00;
	localparam logic [1:0] AXI_SLVERR = 2'b10;

	localparam logic [1:0] PIN_OFF = 2'b00;
	localparam logic [1:0] PIN_JD  = 2'b01;
	localparam logic [1:0] PIN_MIC = 2'b10;

	typedef struct packed {
		logic [15:0] denominator;
		logic [15:0] numerator;
		logic [3:0]  multiplier;
		logic [1:0]  in_divider;
		logic        fractional;
		logic        pll_on;
	} cprc_pll_cfg_t;

	typedef struct packed {
		logic [2:0] pos_gain;
		logic [2:0] neg_gain;
		logic [2:0] aux_gain;
		logic [1:0] diff_boost;
		logic       mixer_on;
		logic [5:0] diff_volume;
		logic       diff_unmute;
		logic       diff_pair_on;
	} cprc_chan_cfg_t;

	typedef struct packed {
		logic       bias_output_on;
		logic       bias_level_select;
		logic       bias_high_perf;
	} cprc_bias_cfg_t;

endpackage

// >>> rtl/cprc_regs.sv
/*
 Register bank of the codec PLL and record path configuration, an AXI4-Lite
 slave. Assumes a well-behaved AXI4-Lite master, one clock, and analog
 blocks that take the decoded settings from the output structs.
*/
`timescale 1ns/1ps

module cprc_regs #(
	parameter int unsigned LOCK_CYCLES = cprc_pkg::LOCK_CYC,
	parameter int unsigned MS_CYCLES   = cprc_pkg::MS_CYC
) (
	input  wire logic                     i_ref_clk,
	input  wire logic                     i_rst_n,
	input  wire logic [17:0]              i_awaddr,
	input  wire logic                     i_awvalid,
	output logic                          o_awready,
	input  wire logic [31:0]              i_wdata,
	input  wire logic [3:0]               i_wstrb,
	input  wire logic                     i_wvalid,
	output logic                          o_wready,
	output logic [1:0]                    o_bresp,
	output logic                          o_bvalid,
	input  wire logic                     i_bready,
	input  wire logic [17:0]              i_araddr,
	input  wire logic                     i_arvalid,
	output logic                          o_arready,
	output logic [31:0]                   o_rdata,
	output logic [1:0]                    o_rresp,
	output logic                          o_rvalid,
	input  wire logic                     i_rready,
	input  wire logic                     i_detect_or_digital_mic_pin,
	output cprc_pkg::cprc_pll_cfg_t       o_pll_cfg,
	output cprc_pkg::cprc_chan_cfg_t      o_left_cfg,
	output cprc_pkg::cprc_chan_cfg_t      o_right_cfg,
	output cprc_pkg::cprc_bias_cfg_t      o_bias_cfg,
	output logic                          o_jack_present,
	output logic                          o_digital_mic_data,
	output logic [5:0]                    o_left_volume_now,
	output logic [5:0]                    o_right_volume_now
);

	localparam int unsigned NREG = 8;

	logic [7:0]  pll_reg [cprc_pkg::PLL_BYTES];
	logic [7:0]  byte_reg [NREG];
	logic        lock_reg;
	logic [31:0] lock_cnt_reg;
	logic [15:0] aw_idx_reg;
	logic        aw_have_reg;
	logic [31:0] w_data_reg;
	logic [3:0]  w_strb_reg;
	logic        w_have_reg;
	logic        bvalid_reg;
	logic [1:0]  bresp_reg;
	logic        rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0]  rresp_reg;
	logic        pin_meta_reg;
	logic        pin_sync_reg;
	logic        jack_reg;
	logic [31:0] deb_cnt_reg;
	logic        mic_reg;
	logic [5:0]  lvol_now_reg;
	logic [5:0]  rvol_now_reg;
	logic [31:0] ramp_cnt_reg;

	// Byte bank order: jack, lmix a, lmix b, rmix a, rmix b, lvol, rvol, bias
	function automatic int map_idx(input logic [15:0] idx);
		if (idx == cprc_pkg::IDX_JACK)
			return 0;
		else if (idx == cprc_pkg::IDX_LMIX_A)
			return 1;
		else if (idx == cprc_pkg::IDX_LMIX_B)
			return 2;
		else if (idx == cprc_pkg::IDX_RMIX_A)
			return 3;
		else if (idx == cprc_pkg::IDX_RMIX_B)
			return 4;
		else if (idx == cprc_pkg::IDX_LVOL)
			return 5;
		else if (idx == cprc_pkg::IDX_RVOL)
			return 6;
		else if (idx == cprc_pkg::IDX_BIAS)
			return 7;
		else
			return -1;
	endfunction

	function automatic logic [7:0] mask_of(input int k);
		case (k)
			0:       return cprc_pkg::MASK_JACK;
			1, 3:    return cprc_pkg::MASK_MIXA;
			2, 4:    return cprc_pkg::MASK_MIXB;
			5, 6:    return cprc_pkg::MASK_VOL;
			default: return cprc_pkg::MASK_BIAS;
		endcase
	endfunction

	// The first level control byte is kept apart: only its ramp rate and ALC fields matter here
	logic [7:0] lvl0_reg;

	wire logic        do_write = aw_have_reg && w_have_reg && !bvalid_reg;
	wire logic [15:0] pll_off  = aw_idx_reg - cprc_pkg::IDX_PLL_BASE;
	wire logic        w_pll    = (aw_idx_reg >= cprc_pkg::IDX_PLL_BASE) &&
		(pll_off < 16'(cprc_pkg::PLL_BYTES));
	wire integer      w_k      = map_idx(aw_idx_reg);
	wire logic        w_lvl    = (aw_idx_reg == cprc_pkg::IDX_LVL0);
	wire logic        w_hit    = w_pll || (w_k >= 0) || w_lvl;
	wire logic [15:0] ar_idx   = i_araddr[17:2];
	wire logic [15:0] ar_off   = ar_idx - cprc_pkg::IDX_PLL_BASE;
	wire logic        r_pll    = (ar_idx >= cprc_pkg::IDX_PLL_BASE) &&
		(ar_off < 16'(cprc_pkg::PLL_BYTES));
	wire integer      r_k      = map_idx(ar_idx);
	wire logic        r_lvl    = (ar_idx == cprc_pkg::IDX_LVL0);
	wire logic        do_read  = i_arvalid && !rvalid_reg;

	logic [7:0] pll_rd;
	always_comb
	begin
		pll_rd = pll_reg[ar_off[2:0]];
		if (ar_off[2:0] == 3'd5)
			pll_rd[cprc_pkg::POS_LOCK] = lock_reg;
	end

	wire logic [7:0] rd_byte = r_pll ? pll_rd : (r_k >= 0) ? byte_reg[r_k[2:0]] :
		r_lvl ? lvl0_reg : 8'h00;

	assign o_awready = !aw_have_reg;
	assign o_wready  = !w_have_reg;
	assign o_arready = !rvalid_reg;
	assign o_bvalid  = bvalid_reg;
	assign o_bresp   = bresp_reg;
	assign o_rvalid  = rvalid_reg;
	assign o_rdata   = rdata_reg;
	assign o_rresp   = rresp_reg;

	// Bus handshake; address and data are latched in either order
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			aw_have_reg <= 1'b0;
			aw_idx_reg  <= 16'h0000;
			w_have_reg  <= 1'b0;
			w_data_reg  <= 32'h0000_0000;
			w_strb_reg  <= 4'h0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= cprc_pkg::AXI_OKAY;
		end
		else
		begin
			if (i_awvalid && !aw_have_reg)
			begin
				aw_have_reg <= 1'b1;
				aw_idx_reg  <= i_awaddr[17:2];
			end
			if (i_wvalid && !w_have_reg)
			begin
				w_have_reg <= 1'b1;
				w_data_reg <= i_wdata;
				w_strb_reg <= i_wstrb;
			end
			if (do_write)
			begin
				aw_have_reg <= 1'b0;
				w_have_reg  <= 1'b0;
				bvalid_reg  <= 1'b1;
				bresp_reg   <= w_hit ? cprc_pkg::AXI_OKAY : cprc_pkg::AXI_SLVERR;
			end
			else if (bvalid_reg && i_bready)
				bvalid_reg <= 1'b0;
		end
	end

	// Each register is one byte in lane 0; only PLL spans several indices
	wire logic wr_en = do_write && w_strb_reg[0];

	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			pll_reg[0] <= cprc_pkg::RST_PLL0;
			pll_reg[1] <= cprc_pkg::RST_PLL1;
			pll_reg[2] <= cprc_pkg::RST_PLL2;
			pll_reg[3] <= cprc_pkg::RST_PLL3;
			pll_reg[4] <= cprc_pkg::RST_PLL4;
			pll_reg[5] <= cprc_pkg::RST_PLL5;
		end
		else if (wr_en && w_pll)
		begin
			if (pll_off[2:0] == 3'd4)
				pll_reg[4] <= w_data_reg[7:0] & cprc_pkg::MASK_PLL4;
			else if (pll_off[2:0] == 3'd5)
				pll_reg[5] <= w_data_reg[7:0] & cprc_pkg::MASK_PLL5;
			else
				pll_reg[pll_off[2:0]] <= w_data_reg[7:0];
		end
	end

	genvar g;
	generate
		for (g = 0; g < NREG; g++)
		begin : g_bytes
			always_ff @(posedge i_ref_clk or negedge i_rst_n)
			begin
				if (!i_rst_n)
					byte_reg[g] <= cprc_pkg::RST_BYTE;
				else if (wr_en && w_k == g)
					byte_reg[g] <= w_data_reg[7:0] & mask_of(g);
			end
		end
	endgenerate

	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			lvl0_reg <= cprc_pkg::RST_BYTE;
		else if (wr_en && w_lvl)
			lvl0_reg <= w_data_reg[7:0] & cprc_pkg::MASK_LVL0;
	end

	// Read channel, answered the cycle after the address is taken
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= 32'h0000_0000;
			rresp_reg  <= cprc_pkg::AXI_OKAY;
		end
		else if (do_read)
		begin
			rvalid_reg <= 1'b1;
			rdata_reg  <= {24'h000000, rd_byte};
			rresp_reg  <= (r_pll || r_k >= 0 || r_lvl) ? cprc_pkg::AXI_OKAY :
				cprc_pkg::AXI_SLVERR;
		end
		else if (rvalid_reg && i_rready)
			rvalid_reg <= 1'b0;
	end

	// Lock model: counts after enable; disabling or retuning drops lock
	wire logic pll_touch = wr_en && w_pll && (pll_off[2:0] != 3'd5);
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			lock_reg     <= 1'b0;
			lock_cnt_reg <= 32'h0000_0000;
		end
		else if (!pll_reg[5][0] || pll_touch)
		begin
			lock_reg     <= 1'b0;
			lock_cnt_reg <= 32'h0000_0000;
		end
		else if (lock_cnt_reg < 32'(LOCK_CYCLES))
			lock_cnt_reg <= lock_cnt_reg + 32'h0000_0001;
		else
			lock_reg <= 1'b1;
	end

	// Integer mode forces fraction terms to zero toward the PLL
	always_comb
	begin
		o_pll_cfg.pll_on      = pll_reg[5][0];
		o_pll_cfg.fractional  = pll_reg[4][0];
		o_pll_cfg.in_divider  = pll_reg[4][2:1];
		o_pll_cfg.multiplier  = pll_reg[4][6:3];
		o_pll_cfg.denominator = pll_reg[4][0] ? {pll_reg[0], pll_reg[1]} : 16'h0000;
		o_pll_cfg.numerator   = pll_reg[4][0] ? {pll_reg[2], pll_reg[3]} : 16'h0000;
	end

	// Gain codes pass as written; reserved codes are not filtered out
	always_comb
	begin
		o_left_cfg.pos_gain      = byte_reg[1][6:4];
		o_left_cfg.neg_gain      = byte_reg[1][3:1];
		o_left_cfg.mixer_on      = byte_reg[1][0];
		o_left_cfg.diff_boost    = byte_reg[2][4:3];
		o_left_cfg.aux_gain      = byte_reg[2][2:0];
		o_left_cfg.diff_volume   = lvol_now_reg;
		o_left_cfg.diff_unmute   = byte_reg[5][1];
		o_left_cfg.diff_pair_on  = byte_reg[5][0];
		o_right_cfg.pos_gain     = byte_reg[3][6:4];
		o_right_cfg.neg_gain     = byte_reg[3][3:1];
		o_right_cfg.mixer_on     = byte_reg[3][0];
		o_right_cfg.diff_boost   = byte_reg[4][4:3];
		o_right_cfg.aux_gain     = byte_reg[4][2:0];
		o_right_cfg.diff_volume  = rvol_now_reg;
		o_right_cfg.diff_unmute  = byte_reg[6][1];
		o_right_cfg.diff_pair_on = byte_reg[6][0];
		o_bias_cfg.bias_output_on    = byte_reg[7][0];
		o_bias_cfg.bias_level_select = byte_reg[7][2];
		o_bias_cfg.bias_high_perf    = byte_reg[7][3];
	end

	// Pin synchroniser and jack debounce
	wire logic [1:0]  pin_func  = byte_reg[0][5:4];
	wire logic        pin_level = pin_sync_reg ^ byte_reg[0][0];
	wire logic [31:0] deb_limit = 32'(cprc_pkg::DEB_BASE_MS * MS_CYCLES)
		<< byte_reg[0][7:6];

	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			pin_meta_reg <= 1'b0;
			pin_sync_reg <= 1'b0;
			jack_reg     <= 1'b0;
			deb_cnt_reg  <= 32'h0000_0000;
			mic_reg      <= 1'b0;
		end
		else
		begin
			pin_meta_reg <= i_detect_or_digital_mic_pin;
			pin_sync_reg <= pin_meta_reg;
			mic_reg      <= (pin_func == cprc_pkg::PIN_MIC) && pin_sync_reg;
			if (pin_func != cprc_pkg::PIN_JD)
			begin
				jack_reg    <= 1'b0;
				deb_cnt_reg <= 32'h0000_0000;
			end
			else if (pin_level == jack_reg)
				deb_cnt_reg <= 32'h0000_0000;
			else if (deb_cnt_reg + 32'h0000_0001 >= deb_limit)
			begin
				jack_reg    <= pin_level;
				deb_cnt_reg <= 32'h0000_0000;
			end
			else
				deb_cnt_reg <= deb_cnt_reg + 32'h0000_0001;
		end
	end

	assign o_jack_present     = jack_reg;
	assign o_digital_mic_data = mic_reg;

	// Volume ramp: one step per tick so a full sweep spans the ramp time
	wire logic [31:0] ramp_limit = 32'((cprc_pkg::RAMP_BASE_MS * MS_CYCLES) /
		cprc_pkg::VOL_STEPS) << lvl0_reg[7:6];
	wire logic        alc_off   = (lvl0_reg[2:0] == 3'b000);
	wire logic        ramp_tick = (ramp_cnt_reg + 32'h0000_0001 >= ramp_limit);

	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			ramp_cnt_reg <= 32'h0000_0000;
			lvol_now_reg <= 6'h00;
			rvol_now_reg <= 6'h00;
		end
		else if (!alc_off)
		begin
			lvol_now_reg <= byte_reg[5][7:2];
			rvol_now_reg <= byte_reg[6][7:2];
			ramp_cnt_reg <= 32'h0000_0000;
		end
		else if (ramp_tick)
		begin
			ramp_cnt_reg <= 32'h0000_0000;
			if (lvol_now_reg < byte_reg[5][7:2])
				lvol_now_reg <= lvol_now_reg + 6'h01;
			else if (lvol_now_reg > byte_reg[5][7:2])
				lvol_now_reg <= lvol_now_reg - 6'h01;
			if (rvol_now_reg < byte_reg[6][7:2])
				rvol_now_reg <= rvol_now_reg + 6'h01;
			else if (rvol_now_reg > byte_reg[6][7:2])
				rvol_now_reg <= rvol_now_reg - 6'h01;
		end
		else
			ramp_cnt_reg <= ramp_cnt_reg + 32'h0000_0001;
	end

	assign o_left_volume_now  = lvol_now_reg;
	assign o_right_volume_now = rvol_now_reg;

endmodule

// >>> tb/cprc_regs_props.sv
/*
 Checker for cprc_regs: bus handshakes and decoded outputs.
 Assumes it is bound to cprc_regs and sees only its ports, one clock.
*/
`timescale 1ns/1ps

module cprc_regs_props (
	input wire logic                     i_ref_clk,
	input wire logic                     i_rst_n,
	input wire logic                     i_awvalid,
	input wire logic                     o_awready,
	input wire logic                     i_wvalid,
	input wire logic                     o_wready,
	input wire logic [1:0]               o_bresp,
	input wire logic                     o_bvalid,
	input wire logic                     i_bready,
	input wire logic [17:0]              i_araddr,
	input wire logic                     i_arvalid,
	input wire logic                     o_arready,
	input wire logic [31:0]              o_rdata,
	input wire logic [1:0]               o_rresp,
	input wire logic                     o_rvalid,
	input wire logic                     i_rready,
	input wire cprc_pkg::cprc_pll_cfg_t  o_pll_cfg,
	input wire cprc_pkg::cprc_chan_cfg_t o_left_cfg,
	input wire logic                     o_jack_present,
	input wire logic                     o_digital_mic_data,
	input wire logic [5:0]               o_left_volume_now
);
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rst_n);
	// Index 0x4009 is a hole inside the bank
	wire logic [15:0] ar_ix = i_araddr[17:2];
	wire logic        ar_map = (ar_ix >= 16'h4002 && ar_ix <= 16'h4008) ||
		(ar_ix >= 16'h400A && ar_ix <= 16'h4011);

	a_int_mode_zero: assert property (
		!o_pll_cfg.fractional |-> {o_pll_cfg.denominator, o_pll_cfg.numerator} == 32'h0)
		else $error("fraction values passed in integer mode");
	a_read_err: assert property (
		i_arvalid && o_arready && !ar_map |=> o_rvalid && o_rresp == 2'b10 && o_rdata == 32'h0)
		else $error("unmapped read not refused");
	a_read_ok: assert property (
		i_arvalid && o_arready && ar_map |=> o_rvalid && o_rresp == 2'b00)
		else $error("mapped read not answered okay");
	a_read_byte: assert property (o_rvalid |-> o_rdata[31:8] == 24'h0)
		else $error("read data wider than one byte");
	a_read_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata) && !o_arready)
		else $error("read answer dropped early");
	a_resp_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
		else $error("write answer dropped early");
	a_write_answer: assert property (i_awvalid && o_awready && i_wvalid && o_wready |-> ##[1:3] o_bvalid)
		else $error("write answer late");
	a_vol_step: assert property (
		$changed(o_left_volume_now) |=> $stable(o_left_volume_now))
		else $error("volume moved on two cycles in a row");
	a_pin_exclusive: assert property (!(o_jack_present && o_digital_mic_data))
		else $error("detect and microphone both active");
	c_write: cover property (i_awvalid && o_awready);
	c_frac: cover property (o_pll_cfg.fractional);
	c_jack: cover property (o_jack_present);
	c_mic: cover property (o_digital_mic_data);
	c_vol: cover property (o_left_cfg.mixer_on && o_left_cfg.diff_volume != 6'h00);
endmodule

bind cprc_regs cprc_regs_props i_cprc_regs_props (
	.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_awvalid(i_awvalid), .o_awready(o_awready),
	.i_wvalid(i_wvalid), .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
	.i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
	.o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready),
	.o_pll_cfg(o_pll_cfg), .o_left_cfg(o_left_cfg), .o_jack_present(o_jack_present),
	.o_digital_mic_data(o_digital_mic_data), .o_left_volume_now(o_left_volume_now)
);

// >>> tb/tb.sv
/*
 Testbench for cprc_regs: AXI4-Lite register tests and output checks.
 Assumes short lock and millisecond counts set through the parameters.
*/
`timescale 1ns/1ps

module tb;
	localparam int LK = 20;
	localparam logic [7:0]  RP [6] = '{8'h00, 8'hFD, 8'h00, 8'h0C, 8'h10, 8'h00};
	localparam logic [15:0] SX [9] = '{16'h4008, 16'h400A, 16'h400B, 16'h400C, 16'h400D,
		16'h400E, 16'h400F, 16'h4010, 16'h4011};
	// Reserved codes are never written, so the jack and boost values differ from all ones
	localparam logic [7:0]  WV [9] = '{8'hE1, 8'hFF, 8'hF7, 8'hFF, 8'hF7, 8'hFF, 8'hFF,
		8'hFF, 8'hBB};
	localparam logic [7:0]  EV [9] = '{8'hE1, 8'h7F, 8'h17, 8'h7F, 8'h17, 8'hFF, 8'hFF,
		8'h0D, 8'hBB};
	logic                     clk = 1'b0;
	logic                     rst_n = 1'b0;
	logic [17:0]              awaddr = '0, araddr = '0;
	logic [31:0]              wdata = '0, rdata, v;
	logic                     awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic                     pin = 0, awready, wready, bvalid, arready, rvalid, jack, mic;
	logic [1:0]               bresp, rresp, r;
	logic [5:0]               lvn, rvn;
	cprc_pkg::cprc_pll_cfg_t  pll;
	cprc_pkg::cprc_chan_cfg_t lc, rcf;
	cprc_pkg::cprc_bias_cfg_t bc;
	int                       mismatches = 0, n_compared = 0;

	always #4 clk = ~clk;

	cprc_regs #(.LOCK_CYCLES(LK), .MS_CYCLES(64)) i_cprc_regs (
		.i_ref_clk(clk), .i_rst_n(rst_n), .i_awaddr(awaddr), .i_awvalid(awvalid),
		.o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wvalid),
		.o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
		.i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
		.o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
		.i_detect_or_digital_mic_pin(pin), .o_pll_cfg(pll), .o_left_cfg(lc),
		.o_right_cfg(rcf), .o_bias_cfg(bc), .o_jack_present(jack), .o_digital_mic_data(mic),
		.o_left_volume_now(lvn), .o_right_volume_now(rvn));

	task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
		n_compared++;
		if (g !== e)
		begin
			mismatches++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_rsp(input string nm, input logic [1:0] e, input logic [1:0] g);
		chk(nm, 48'(e), 48'(g));
	endtask
	task automatic wr(input logic [15:0] ix, input logic [7:0] d, input logic [1:0] er);
		logic a, w, b;
		@(posedge clk);
		{a, w, b} = 3'b111;
		awaddr <= {ix, 2'b00};
		wdata <= {24'h0, d};
		{awvalid, wvalid, bready} <= 3'b111;
		while (b)
		begin
			@(posedge clk);
			if (a && awready)
			begin
				a = 0;
				awvalid <= 0;
			end
			if (w && wready)
			begin
				w = 0;
				wvalid <= 0;
			end
			if (bvalid)
			begin
				b = 0;
				bready <= 0;
				chk_rsp("bresp", er, bresp);
			end
		end
	endtask
	task automatic rd(input logic [15:0] ix, output logic [31:0] d, output logic [1:0] rs);
		logic a, b;
		@(posedge clk);
		{a, b} = 2'b11;
		araddr <= {ix, 2'b00};
		{arvalid, rready} <= 2'b11;
		while (b)
		begin
			@(posedge clk);
			if (a && arready)
			begin
				a = 0;
				arvalid <= 0;
			end
			else if (!a && rvalid)
			begin
				b = 0;
				rready <= 0;
				d = rdata;
				rs = rresp;
			end
		end
	endtask
	task automatic w(input logic [15:0] ix, input logic [7:0] d);
		wr(ix, d, 2'b00);
	endtask
	task automatic rc(input logic [15:0] ix, input logic [7:0] e);
		rd(ix, v, r);
		chk("rdata", 48'(e), 48'(v));
		chk_rsp("rresp", 2'b00, r);
	endtask
	task automatic end_sim;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial
	begin
		repeat (20000) @(posedge clk);
		mismatches++;
		$display("FAIL watchdog expected finish seen hang");
		end_sim();
	end

	initial
	begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		chk("pll", 48'({32'h0, 4'h2, 2'h0, 2'b00}), 48'(pll));
		for (int k = 0; k < 6; k++) rc(16'(16'h4002 + k), RP[k]);
		for (int k = 0; k < 9; k++) rc(SX[k], 8'h00);
		$display("test reset done");
		for (int k = 0; k < 9; k++)
		begin
			w(SX[k], WV[k]);
			rc(SX[k], EV[k]);
		end
		for (int k = 0; k < 9; k++) w(SX[k], 8'h00);
		$display("test masks done");
		w(16'h4002, 8'hA5);
		w(16'h4003, 8'hC3);
		w(16'h4004, 8'h12);
		w(16'h4005, 8'h34);
		w(16'h4006, 8'h47);
		chk("pll", 48'({32'hA5C31234, 4'h8, 2'h3, 2'b10}), 48'(pll));
		w(16'h4006, 8'h46);
		chk("pll", 48'({32'h0, 4'h8, 2'h3, 2'b00}), 48'(pll));
		rc(16'h4002, 8'hA5);
		w(16'h4007, 8'h01);
		rc(16'h4007, 8'h01);
		chk("pll_on", 48'(1), 48'(pll.pll_on));
		repeat (LK + 4) @(posedge clk);
		rc(16'h4007, 8'h03);
		w(16'h4006, 8'h10);
		rc(16'h4007, 8'h01);
		w(16'h4007, 8'h00);
		rc(16'h4007, 8'h00);
		$display("test pll done");
		rd(16'h4009, v, r);
		chk("rdata", 48'(0), 48'(v));
		chk_rsp("rresp", 2'b10, r);
		wr(16'h4009, 8'h5A, 2'b10);
		w(16'h4010, 8'h0D);
		chk("bias", 48'(3'b111), 48'(bc));
		w(16'h4010, 8'h04);
		chk("bias", 48'(3'b010), 48'(bc));
		$display("test errors and bias done");
		w(16'h4008, 8'h10);
		repeat (400) @(posedge clk);
		chk("jack", 48'(0), 48'(jack));
		pin <= 1;
		repeat (150) @(posedge clk);
		chk("jack", 48'(0), 48'(jack));
		repeat (250) @(posedge clk);
		chk("jack", 48'(1), 48'(jack));
		w(16'h4008, 8'h51);
		repeat (800) @(posedge clk);
		chk("jack", 48'(0), 48'(jack));
		pin <= 0;
		repeat (400) @(posedge clk);
		chk("jack", 48'(0), 48'(jack));
		repeat (350) @(posedge clk);
		chk("jack", 48'(1), 48'(jack));
		w(16'h4008, 8'h20);
		repeat (4) @(posedge clk);
		chk("jack", 48'(0), 48'(jack));
		pin <= 1;
		repeat (5) @(posedge clk);
		chk("mic", 48'(1), 48'(mic));
		w(16'h4008, 8'h00);
		repeat (5) @(posedge clk);
		chk("mic", 48'(0), 48'(mic));
		w(16'h4008, 8'h90);
		repeat (1200) @(posedge clk);
		chk("jack", 48'(0), 48'(jack));
		repeat (150) @(posedge clk);
		chk("jack", 48'(1), 48'(jack));
		w(16'h4008, 8'hD1);
		repeat (2450) @(posedge clk);
		chk("jack", 48'(1), 48'(jack));
		repeat (200) @(posedge clk);
		chk("jack", 48'(0), 48'(jack));
		$display("test jack done");
		w(16'h400A, 8'h6B);
		w(16'h400B, 8'h13);
		w(16'h400C, 8'h15);
		w(16'h400D, 8'h0C);
		chk("lvol", 48'(0), 48'(lvn));
		w(16'h400E, 8'h43);
		// Sixteen steps of 24 cycles each; check midway and after the end
		repeat (192) @(posedge clk);
		chk("ramping", 48'(1), 48'(lvn > 0 && lvn < 16));
		repeat (250) @(posedge clk);
		chk("left", 48'({12'hD5D, 6'd16, 2'b11}), 48'(lc));
		w(16'h4011, 8'h40);
		w(16'h400E, 8'h03);
		repeat (400) @(posedge clk);
		chk("ramping", 48'(1), 48'(lvn > 0 && lvn < 16));
		repeat (450) @(posedge clk);
		chk("lvol", 48'(0), 48'(lvn));
		// Ramp rate 2, 96 cycles per step: first step lands anywhere in the first 96 cycles
		w(16'h4011, 8'h80);
		w(16'h400E, 8'h13);
		repeat (190) @(posedge clk);
		chk("ramping", 48'(1), 48'(lvn > 0 && lvn < 3));
		repeat (250) @(posedge clk);
		chk("lvol", 48'(4), 48'(lvn));
		w(16'h4011, 8'h01);
		w(16'h400F, 8'hFE);
		repeat (4) @(posedge clk);
		chk("right", 48'({12'h2A3, 6'd63, 2'b10}), 48'(rcf));
		chk("rvol", 48'(63), 48'(rvn));
		$display("test volume done");
		end_sim();
	end
endmodule
